// ### logic/cces_cfg.svh
`ifndef CCES_CFG_SVH
`define CCES_CFG_SVH

`define CCES_AW 16
`define CCES_DW 16
`define CCES_NUM_BUF 16
`define CCES_NUM_SLOT 8
`define CCES_CYC_W 6
`define CCES_MT_W 14
`define CCES_SYNC_W 5

`define CCES_ADDR_EVENT_STATUS 16'h000e
`define CCES_ADDR_EVENT_ENABLE 16'h0016
`define CCES_ADDR_SLOT_MASK 16'h0018
`define CCES_ADDR_MAX_SYNC 16'h001a
`define CCES_ADDR_TIMER0_CFG 16'h0020
`define CCES_ADDR_TIMER0_OFF 16'h0022
`define CCES_ADDR_TIMER1_CFG 16'h0024
`define CCES_ADDR_TIMER1_OFF 16'h0026
`define CCES_ADDR_ERROR_LEVEL 16'h0328

`define CCES_RST_EVENT_STATUS 16'h0000
`define CCES_RST_EVENT_ENABLE 16'h0000
`define CCES_RST_TIMER_CFG 16'h0000
`define CCES_RST_TIMER_OFF 14'h0000
`define CCES_RST_SLOT_MASK 8'h00
`define CCES_RST_MAX_SYNC 5'h0f

`define CCES_TCFG_BASE_LSB 0
`define CCES_TCFG_REP_LSB 8

`define CCES_BIT_RX 0
`define CCES_BIT_TX 1
`define CCES_BIT_HIE 2
`define CCES_BIT_FNE 3
`define CCES_BIT_FOV 4
`define CCES_BIT_CYC 5
`define CCES_BIT_TIM0 6
`define CCES_BIT_TIM1 7
`define CCES_BIT_MOC 8
`define CCES_BIT_BGS 9
`define CCES_BIT_SLOT 10
`define CCES_BIT_MRC 11
`define CCES_BIT_LVL 12
`define CCES_BIT_SYNC 13
`define CCES_BIT_CCL 14
`define CCES_BIT_FATAL 15

`endif

// ### logic/cces_pkg.sv
`include "cces_cfg.svh"
`default_nettype none
package cces_pkg;

   typedef enum logic [1:0] {
      CCES_LVL_GREEN = 2'h0,
      CCES_LVL_YELLOW = 2'h1,
      CCES_LVL_RED = 2'h2,
      CCES_LVL_UNUSED = 2'h3
   } cces_level_type;

   typedef struct packed {
      logic [`CCES_AW-1:0] addr;
      logic [`CCES_DW-1:0] wdata;
      logic wr;
      logic rd;
   } cces_bus_req_type;

   typedef struct packed {
      logic cycle_start;
      logic cycle_end;
      logic cycle_odd;
      logic offset_short;
      logic rate_short;
      logic fifo_overrun;
      logic corr_limit;
      logic fatal;
      logic sync_frame;
      logic [1:0] guardian_err;
   } cces_proto_evt_type;

endpackage
`default_nettype wire

// ### logic/cces_flag_cell.sv
`include "cces_cfg.svh"
`default_nettype none
module cces_flag_cell (
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic set_in,
   input wire logic hold_in,
   input wire logic drop_in,
   input wire logic clr_in,
   input wire logic wipe_in,
   output logic flag_out
);
   logic flag_r;
   logic flag_nxt;

   // A detected condition beats a software clear in the same cycle.
   always_comb begin
      flag_nxt = flag_r;
      if (wipe_in) begin
         flag_nxt = 1'b0;
      end else if (set_in) begin
         flag_nxt = 1'b1;
      end else if (drop_in || (clr_in && !hold_in)) begin
         flag_nxt = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         flag_r <= 1'b0;
      end else begin
         flag_r <= flag_nxt;
      end
   end

   assign flag_out = flag_r;
endmodule
`default_nettype wire

// ### logic/cces_event_status.sv
`include "cces_cfg.svh"
`default_nettype none
module cces_event_status
   import cces_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire cces_bus_req_type bus_req_in,
   input wire logic config_active_in,
   input wire logic [1:0] error_level_in,
   input wire cces_proto_evt_type proto_evt_in,
   input wire logic [`CCES_NUM_BUF-1:0] rx_buffer_irq_flag_in,
   input wire logic [`CCES_NUM_BUF-1:0] rx_buffer_irq_enable_in,
   input wire logic [`CCES_NUM_BUF-1:0] tx_buffer_irq_flag_in,
   input wire logic [`CCES_NUM_BUF-1:0] tx_buffer_irq_enable_in,
   input wire logic [`CCES_DW-1:0] host_if_error_in,
   input wire logic fifo_not_empty_in,
   input wire logic buffer0_locked_in,
   input wire logic [`CCES_NUM_SLOT-1:0] slot_counter_inc_in,
   input wire logic [`CCES_CYC_W-1:0] cycle_count_in,
   input wire logic [`CCES_MT_W-1:0] macrotick_count_in,
   output logic [`CCES_DW-1:0] rd_data_out,
   output logic irq_pending_out,
   output logic diag_stop_out,
   output logic [1:0] error_level_out
);

   function automatic logic hit(input logic [`CCES_AW-1:0] a, input logic [`CCES_AW-1:0] reg_addr);
      hit = (a == reg_addr);
   endfunction

   logic [`CCES_DW-1:0] event_status_reg;
   logic [`CCES_DW-1:0] set_vec;
   logic [`CCES_DW-1:0] hold_vec;
   logic [`CCES_DW-1:0] drop_vec;
   logic [`CCES_DW-1:0] clr_vec;
   logic wipe;
   logic [1:0] timer_hit;

   logic [`CCES_DW-1:0] event_enable_r, event_enable_nxt;
   logic [`CCES_NUM_SLOT-1:0] slot_mask_r, slot_mask_nxt;
   logic [`CCES_SYNC_W-1:0] max_sync_r, max_sync_nxt;
   logic [`CCES_SYNC_W-1:0] sync_cnt_r, sync_cnt_nxt;
   logic [`CCES_DW-1:0] timer_cfg_r [2];
   logic [`CCES_DW-1:0] timer_cfg_nxt [2];
   logic [`CCES_MT_W-1:0] timer_off_r [2];
   logic [`CCES_MT_W-1:0] timer_off_nxt [2];
   logic [1:0] error_level_r, error_level_nxt;
   logic config_prev_r, config_prev_nxt;
   logic diag_stop_r, diag_stop_nxt;
   logic irq_r, irq_nxt;
   logic [`CCES_DW-1:0] rd_data_r, rd_data_nxt;

   logic wr_status;
   logic rx_cond, tx_cond, hie_cond, sync_over;

   assign wr_status = bus_req_in.wr && hit(bus_req_in.addr, `CCES_ADDR_EVENT_STATUS);
   assign wipe = config_prev_r && !config_active_in;

   // Timer match: cycle counter and base agree under the repetition mask, and macrotick equals the offset.
   genvar t;
   generate
      for (t = 0; t < 2; t++) begin : g_timer
         logic [`CCES_CYC_W-1:0] base;
         logic [`CCES_CYC_W-1:0] rep;
         assign base = timer_cfg_r[t][`CCES_TCFG_BASE_LSB +: `CCES_CYC_W];
         assign rep = timer_cfg_r[t][`CCES_TCFG_REP_LSB +: `CCES_CYC_W];
         assign timer_hit[t] = ((cycle_count_in & rep) == (base & rep)) &&
                               (macrotick_count_in == timer_off_r[t]);
      end
   endgenerate

   assign rx_cond = |(rx_buffer_irq_flag_in & rx_buffer_irq_enable_in);
   assign tx_cond = |(tx_buffer_irq_flag_in & tx_buffer_irq_enable_in);
   assign hie_cond = |host_if_error_in;
   assign sync_over = proto_evt_in.sync_frame && (sync_cnt_r >= max_sync_r);

   always_comb begin
      set_vec = '0;
      hold_vec = '0;
      drop_vec = '0;
      set_vec[`CCES_BIT_RX] = rx_cond;
      set_vec[`CCES_BIT_TX] = tx_cond;
      set_vec[`CCES_BIT_HIE] = hie_cond;
      set_vec[`CCES_BIT_FNE] = fifo_not_empty_in;
      set_vec[`CCES_BIT_FOV] = proto_evt_in.fifo_overrun;
      set_vec[`CCES_BIT_CYC] = proto_evt_in.cycle_start;
      set_vec[`CCES_BIT_TIM0] = timer_hit[0];
      set_vec[`CCES_BIT_TIM1] = timer_hit[1];
      set_vec[`CCES_BIT_MOC] = proto_evt_in.cycle_end && proto_evt_in.offset_short;
      set_vec[`CCES_BIT_BGS] = |proto_evt_in.guardian_err;
      set_vec[`CCES_BIT_SLOT] = |(slot_counter_inc_in & slot_mask_r);
      set_vec[`CCES_BIT_MRC] = proto_evt_in.cycle_end && proto_evt_in.cycle_odd &&
                               proto_evt_in.rate_short;
      set_vec[`CCES_BIT_LVL] = (error_level_nxt != error_level_r);
      set_vec[`CCES_BIT_SYNC] = sync_over;
      set_vec[`CCES_BIT_CCL] = proto_evt_in.corr_limit;
      set_vec[`CCES_BIT_FATAL] = proto_evt_in.fatal;
      hold_vec[`CCES_BIT_RX] = rx_cond;
      hold_vec[`CCES_BIT_TX] = tx_cond;
      hold_vec[`CCES_BIT_HIE] = hie_cond;
      hold_vec[`CCES_BIT_FNE] = fifo_not_empty_in || buffer0_locked_in;
      // The FIFO flag falls on its own once the FIFO is drained and released.
      drop_vec[`CCES_BIT_FNE] = !fifo_not_empty_in && !buffer0_locked_in;
      // The transmit flag is read-only: it simply follows its condition.
      drop_vec[`CCES_BIT_TX] = !tx_cond;
      clr_vec = wr_status ? bus_req_in.wdata : '0;
   end

   genvar b;
   generate
      for (b = 0; b < `CCES_DW; b++) begin : g_flag
         cces_flag_cell u_cell (
            .sys_clk_in(sys_clk_in),
            .rstn_in(rstn_in),
            .set_in(set_vec[b]),
            .hold_in(hold_vec[b]),
            .drop_in(drop_vec[b]),
            .clr_in(clr_vec[b]),
            .wipe_in(wipe),
            .flag_out(event_status_reg[b])
         );
      end
   endgenerate

   always_comb begin
      event_enable_nxt = event_enable_r;
      slot_mask_nxt = slot_mask_r;
      max_sync_nxt = max_sync_r;
      timer_cfg_nxt = timer_cfg_r;
      timer_off_nxt = timer_off_r;
      if (bus_req_in.wr) begin
         if (hit(bus_req_in.addr, `CCES_ADDR_EVENT_ENABLE)) begin
            event_enable_nxt = bus_req_in.wdata;
         end
         if (hit(bus_req_in.addr, `CCES_ADDR_SLOT_MASK)) begin
            slot_mask_nxt = bus_req_in.wdata[`CCES_NUM_SLOT-1:0];
         end
         if (hit(bus_req_in.addr, `CCES_ADDR_MAX_SYNC)) begin
            max_sync_nxt = bus_req_in.wdata[`CCES_SYNC_W-1:0];
         end
         if (hit(bus_req_in.addr, `CCES_ADDR_TIMER0_CFG)) begin
            timer_cfg_nxt[0] = bus_req_in.wdata;
         end
         if (hit(bus_req_in.addr, `CCES_ADDR_TIMER0_OFF)) begin
            timer_off_nxt[0] = bus_req_in.wdata[`CCES_MT_W-1:0];
         end
         if (hit(bus_req_in.addr, `CCES_ADDR_TIMER1_CFG)) begin
            timer_cfg_nxt[1] = bus_req_in.wdata;
         end
         if (hit(bus_req_in.addr, `CCES_ADDR_TIMER1_OFF)) begin
            timer_off_nxt[1] = bus_req_in.wdata[`CCES_MT_W-1:0];
         end
      end
      // Saturating per-cycle count of sync frames; a new cycle restarts it.
      sync_cnt_nxt = sync_cnt_r;
      if (proto_evt_in.cycle_start) begin
         sync_cnt_nxt = '0;
      end else if (proto_evt_in.sync_frame && (sync_cnt_r != {`CCES_SYNC_W{1'b1}})) begin
         sync_cnt_nxt = sync_cnt_r + `CCES_SYNC_W'(1);
      end
      config_prev_nxt = config_active_in;
      // Once fatal, the level stays red until hard reset; the engine cannot talk it back down.
      diag_stop_nxt = diag_stop_r || proto_evt_in.fatal;
      error_level_nxt = diag_stop_nxt ? CCES_LVL_RED : error_level_in;
      irq_nxt = |(event_status_reg & event_enable_r);
      rd_data_nxt = '0;
      if (bus_req_in.rd) begin
         if (hit(bus_req_in.addr, `CCES_ADDR_EVENT_STATUS)) begin
            rd_data_nxt = event_status_reg;
         end else if (hit(bus_req_in.addr, `CCES_ADDR_ERROR_LEVEL)) begin
            rd_data_nxt = {14'h0000, error_level_r};
         end else if (hit(bus_req_in.addr, `CCES_ADDR_EVENT_ENABLE)) begin
            rd_data_nxt = event_enable_r;
         end else if (hit(bus_req_in.addr, `CCES_ADDR_SLOT_MASK)) begin
            rd_data_nxt = {8'h00, slot_mask_r};
         end else if (hit(bus_req_in.addr, `CCES_ADDR_MAX_SYNC)) begin
            rd_data_nxt = {11'h000, max_sync_r};
         end else if (hit(bus_req_in.addr, `CCES_ADDR_TIMER0_CFG)) begin
            rd_data_nxt = timer_cfg_r[0];
         end else if (hit(bus_req_in.addr, `CCES_ADDR_TIMER0_OFF)) begin
            rd_data_nxt = {2'h0, timer_off_r[0]};
         end else if (hit(bus_req_in.addr, `CCES_ADDR_TIMER1_CFG)) begin
            rd_data_nxt = timer_cfg_r[1];
         end else if (hit(bus_req_in.addr, `CCES_ADDR_TIMER1_OFF)) begin
            rd_data_nxt = {2'h0, timer_off_r[1]};
         end
      end
   end

   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         event_enable_r <= `CCES_RST_EVENT_ENABLE;
         slot_mask_r <= `CCES_RST_SLOT_MASK;
         max_sync_r <= `CCES_RST_MAX_SYNC;
         timer_cfg_r[0] <= `CCES_RST_TIMER_CFG;
         timer_cfg_r[1] <= `CCES_RST_TIMER_CFG;
         timer_off_r[0] <= `CCES_RST_TIMER_OFF;
         timer_off_r[1] <= `CCES_RST_TIMER_OFF;
         sync_cnt_r <= '0;
         config_prev_r <= 1'b0;
         diag_stop_r <= 1'b0;
         error_level_r <= CCES_LVL_GREEN;
         irq_r <= 1'b0;
         rd_data_r <= '0;
      end else begin
         event_enable_r <= event_enable_nxt;
         slot_mask_r <= slot_mask_nxt;
         max_sync_r <= max_sync_nxt;
         timer_cfg_r <= timer_cfg_nxt;
         timer_off_r <= timer_off_nxt;
         sync_cnt_r <= sync_cnt_nxt;
         config_prev_r <= config_prev_nxt;
         diag_stop_r <= diag_stop_nxt;
         error_level_r <= error_level_nxt;
         irq_r <= irq_nxt;
         rd_data_r <= rd_data_nxt;
      end
   end

   assign rd_data_out = rd_data_r;
   assign irq_pending_out = irq_r;
   assign diag_stop_out = diag_stop_r;
   assign error_level_out = error_level_r;

   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!rstn_in);

   sequence s_leave_config;
      config_prev_r && !config_active_in;
   endsequence

   sequence s_level_move;
      !diag_stop_r && !proto_evt_in.fatal && (error_level_in != error_level_r);
   endsequence

   property p_level_track;
      !diag_stop_r && !proto_evt_in.fatal |=> error_level_out == $past(error_level_in);
   endproperty
   a_level_track: assert property (p_level_track) else $error("error level not tracking");

   // Bits that the device sets or drops in the write cycle are left out, so the check bites on every event status write except one in a wipe cycle.
   property p_zero_keeps;
      wr_status && !wipe |=>
         ((event_status_reg ^ $past(event_status_reg)) & ~$past(bus_req_in.wdata) & ~$past(set_vec) &
          ~$past(drop_vec)) == '0;
   endproperty
   a_zero_keeps: assert property (p_zero_keeps) else $error("zero write changed a flag");

   property p_one_clears;
      wr_status && !wipe && bus_req_in.wdata[`CCES_BIT_FOV] && !proto_evt_in.fifo_overrun |=>
         !event_status_reg[`CCES_BIT_FOV];
   endproperty
   a_one_clears: assert property (p_one_clears) else $error("one write did not clear");

   property p_set_again;
      !wipe |=> (event_status_reg & $past(set_vec)) == $past(set_vec);
   endproperty
   a_set_again: assert property (p_set_again) else $error("detected event lost");

   property p_hold_rx;
      wr_status && !wipe && bus_req_in.wdata[`CCES_BIT_RX] && rx_cond |=> event_status_reg[`CCES_BIT_RX];
   endproperty
   a_hold_rx: assert property (p_hold_rx) else $error("receive flag cleared under live cause");

   property p_wipe;
      s_leave_config |=> event_status_reg == '0;
   endproperty
   a_wipe: assert property (p_wipe) else $error("status not cleared on leaving config");

   property p_pending;
      ((event_status_reg & event_enable_r) != '0) [*2] |-> irq_pending_out;
   endproperty
   a_pending: assert property (p_pending) else $error("enabled flag without pending");

   property p_tx_follow;
      !wipe |=> event_status_reg[`CCES_BIT_TX] == $past(tx_cond);
   endproperty
   a_tx_follow: assert property (p_tx_follow) else $error("transmit flag off its condition");

   property p_hie;
      hie_cond && !wipe |=> event_status_reg[`CCES_BIT_HIE];
   endproperty
   a_hie: assert property (p_hie) else $error("host error flag missing");

   property p_fifo_drop;
      !fifo_not_empty_in && !buffer0_locked_in |=> !event_status_reg[`CCES_BIT_FNE];
   endproperty
   a_fifo_drop: assert property (p_fifo_drop) else $error("FIFO flag stuck after drain");

   property p_cycle;
      proto_evt_in.cycle_start && !wipe |=> event_status_reg[`CCES_BIT_CYC];
   endproperty
   a_cycle: assert property (p_cycle) else $error("cycle start flag missing");

   property p_timer;
      timer_hit[0] && !wipe |=> event_status_reg[`CCES_BIT_TIM0];
   endproperty
   a_timer: assert property (p_timer) else $error("timer zero flag missing");

   property p_timer_reset;
      $rose(rstn_in) |-> ##1 (event_status_reg[`CCES_BIT_TIM1:`CCES_BIT_TIM0] == 2'h3) && !irq_pending_out;
   endproperty
   a_timer_reset: assert property (@(posedge sys_clk_in) p_timer_reset) else $error("timer flags not shown after reset");

   property p_rate;
      proto_evt_in.cycle_end && !proto_evt_in.cycle_odd && !wipe &&
         !event_status_reg[`CCES_BIT_MRC] && !wr_status |=> !event_status_reg[`CCES_BIT_MRC];
   endproperty
   a_rate: assert property (p_rate) else $error("rate flag set on even cycle");

   property p_level_flag;
      s_level_move ##0 !wipe |=> event_status_reg[`CCES_BIT_LVL];
   endproperty
   a_level_flag: assert property (p_level_flag) else $error("level change not flagged");

   property p_fatal;
      proto_evt_in.fatal |=> diag_stop_out && error_level_out == CCES_LVL_RED;
   endproperty
   a_fatal: assert property (p_fatal) else $error("fatal did not force diagnosis stop");

endmodule
`default_nettype wire

// ### testbench/cces_host_model.sv
`include "cces_cfg.svh"
`default_nettype none
module cces_host_model
   import cces_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic [`CCES_DW-1:0] rd_data_in,
   output var cces_bus_req_type bus_req_out
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      bus_req_out = '0;
   end

   // Software clears flags only by writing ones; a zero leaves a flag alone.
   // The host may write a clear to a self-refreshing flag while its cause is live; such a clear is ignored.
   // The trailing idle edge keeps back-to-back calls from driving a strobe twice in one step.
   task automatic write_reg(input logic [`CCES_AW-1:0] addr, input logic [`CCES_DW-1:0] data);
      bus_req_out.addr <= addr;
      bus_req_out.wdata <= data;
      bus_req_out.wr <= 1'b1;
      @(posedge sys_clk_in);
      bus_req_out.wr <= 1'b0;
      @(posedge sys_clk_in);
   endtask

   task automatic read_reg(input logic [`CCES_AW-1:0] addr, output logic [`CCES_DW-1:0] data);
      bus_req_out.addr <= addr;
      bus_req_out.rd <= 1'b1;
      @(posedge sys_clk_in);
      bus_req_out.rd <= 1'b0;
      #1;
      data = rd_data_in;
      @(posedge sys_clk_in);
   endtask
endmodule
`default_nettype wire

// ### testbench/tb_comm_ctrl_event_status.sv
`include "cces_cfg.svh"
`default_nettype none
module tb_comm_ctrl_event_status
   import cces_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   localparam logic [15:0] ES = `CCES_ADDR_EVENT_STATUS;
   localparam logic [15:0] LV = `CCES_ADDR_ERROR_LEVEL;
   logic clk, rstn, cfg, fne, b0l, irq, diag;
   logic [1:0] lvl, lvl_out;
   logic [15:0] rxf, rxe, txf, txe, hie, rd_data;
   logic [7:0] slot;
   logic [5:0] cyc;
   logic [13:0] mt;
   cces_proto_evt_type evt;
   cces_bus_req_type bus;
   int err_total = 0;
   int checks_done = 0;

   cces_host_model host (.sys_clk_in(clk), .rd_data_in(rd_data), .bus_req_out(bus));

   cces_event_status uut (.sys_clk_in(clk), .rstn_in(rstn), .bus_req_in(bus), .config_active_in(cfg),
      .error_level_in(lvl), .proto_evt_in(evt), .rx_buffer_irq_flag_in(rxf), .rx_buffer_irq_enable_in(rxe),
      .tx_buffer_irq_flag_in(txf), .tx_buffer_irq_enable_in(txe), .host_if_error_in(hie),
      .fifo_not_empty_in(fne), .buffer0_locked_in(b0l), .slot_counter_inc_in(slot), .cycle_count_in(cyc),
      .macrotick_count_in(mt), .rd_data_out(rd_data), .irq_pending_out(irq), .diag_stop_out(diag),
      .error_level_out(lvl_out));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic expect_reg(input string what, input logic [15:0] addr, input logic [15:0] mask,
                             input logic [15:0] exp);
      logic [15:0] v;
      host.read_reg(addr, v);
      check(what, v & mask, exp);
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic pulse(input cces_proto_evt_type e);
      evt <= e;
      @(posedge clk);
      evt <= '0;
      @(posedge clk);
   endtask

   task automatic ev_case(input string what, input cces_proto_evt_type e, input logic [15:0] exp);
      pulse(e);
      expect_reg(what, ES, 16'hffff, exp);
      host.write_reg(ES, 16'hffff);
   endtask

   task automatic t_reset;
      expect_reg("status after reset", ES, 16'hffff, 16'h00c0);
      #1;
      check("irq after reset", {15'h0000, irq}, 16'h0000);
      step(1);
      expect_reg("level after reset", LV, 16'hffff, 16'h0000);
      mt <= 14'h0001;
      cfg <= 1'b0;
      step(2);
      expect_reg("status after config exit", ES, 16'hffff, 16'h0000);
      $display("test reset done");
   endtask

   task automatic t_clear;
      cces_proto_evt_type e;
      e = '0;
      e.cycle_start = 1'b1;
      pulse(e);
      expect_reg("cycle flag", ES, 16'hffff, 16'h0020);
      host.write_reg(ES, 16'hffdf);
      expect_reg("zero write keeps flag", ES, 16'hffff, 16'h0020);
      host.write_reg(ES, 16'h0020);
      expect_reg("one write clears flag", ES, 16'hffff, 16'h0000);
      pulse(e);
      expect_reg("flag sets again", ES, 16'hffff, 16'h0020);
      host.write_reg(ES, 16'h0020);
      evt <= e;
      fork
         begin
            @(posedge clk);
            evt <= '0;
         end
      join_none
      host.write_reg(ES, 16'h0020);
      expect_reg("set beats clear", ES, 16'hffff, 16'h0020);
      host.write_reg(ES, 16'hffff);
      $display("test clear done");
   endtask

   task automatic t_causes;
      rxf <= 16'h0002;
      rxe <= 16'h0001;
      step(2);
      expect_reg("disabled receive buffer", ES, 16'h0001, 16'h0000);
      rxe <= 16'h0002;
      txf <= 16'h0100;
      txe <= 16'h0100;
      hie <= 16'h8000;
      fne <= 1'b1;
      b0l <= 1'b1;
      step(2);
      expect_reg("cause flags", ES, 16'h000f, 16'h000f);
      host.write_reg(ES, 16'h000f);
      expect_reg("clear ignored under cause", ES, 16'h000f, 16'h000f);
      rxf <= 16'h0000;
      txf <= 16'h0000;
      hie <= 16'h0000;
      fne <= 1'b0;
      step(2);
      host.write_reg(ES, 16'h0007);
      expect_reg("fifo flag held by lock", ES, 16'h000f, 16'h0008);
      b0l <= 1'b0;
      step(2);
      expect_reg("fifo flag drops", ES, 16'h000f, 16'h0000);
      $display("test causes done");
   endtask

   task automatic t_events;
      cces_proto_evt_type e;
      e = '0;
      e.fifo_overrun = 1'b1;
      ev_case("overrun flag", e, 16'h0010);
      e = '0;
      e.corr_limit = 1'b1;
      ev_case("limit flag", e, 16'h4000);
      for (int ch = 1; ch < 3; ch++) begin
         e = '0;
         e.guardian_err = ch[1:0];
         ev_case("guardian flag", e, 16'h0200);
      end
      e = '0;
      e.cycle_end = 1'b1;
      e.offset_short = 1'b1;
      ev_case("offset flag even", e, 16'h0100);
      e.offset_short = 1'b0;
      e.rate_short = 1'b1;
      ev_case("rate flag even", e, 16'h0000);
      e.cycle_odd = 1'b1;
      ev_case("rate flag odd", e, 16'h0800);
      host.write_reg(`CCES_ADDR_SLOT_MASK, 16'h0001);
      slot <= 8'h02;
      step(1);
      slot <= 8'h00;
      expect_reg("masked slot counter", ES, 16'h0400, 16'h0000);
      slot <= 8'h01;
      step(1);
      slot <= 8'h00;
      expect_reg("slot flag", ES, 16'h0400, 16'h0400);
      host.write_reg(`CCES_ADDR_MAX_SYNC, 16'h0002);
      e = '0;
      e.cycle_start = 1'b1;
      pulse(e);
      e = '0;
      e.sync_frame = 1'b1;
      pulse(e);
      pulse(e);
      expect_reg("sync at maximum", ES, 16'h2000, 16'h0000);
      pulse(e);
      expect_reg("sync overflow", ES, 16'h2000, 16'h2000);
      host.write_reg(ES, 16'hffff);
      $display("test events done");
   endtask

   task automatic t_timer;
      host.write_reg(`CCES_ADDR_TIMER0_CFG, 16'h3f03);
      host.write_reg(`CCES_ADDR_TIMER0_OFF, 16'h0005);
      cyc <= 6'h03;
      mt <= 14'h0005;
      step(2);
      expect_reg("timer match", ES, 16'h00c0, 16'h0040);
      cyc <= 6'h05;
      host.write_reg(ES, 16'h00c0);
      expect_reg("timer cycle mismatch", ES, 16'h00c0, 16'h0000);
      host.write_reg(`CCES_ADDR_TIMER0_CFG, 16'h0103);
      expect_reg("timer repetition match", ES, 16'h00c0, 16'h0040);
      host.write_reg(`CCES_ADDR_TIMER1_CFG, 16'h0005);
      host.write_reg(`CCES_ADDR_TIMER1_OFF, 16'h0007);
      mt <= 14'h0007;
      host.write_reg(ES, 16'h00c0);
      expect_reg("timer one match", ES, 16'h00c0, 16'h0080);
      mt <= 14'h0001;
      host.write_reg(ES, 16'hffff);
      $display("test timer done");
   endtask

   task automatic t_irq;
      cces_proto_evt_type e;
      e = '0;
      e.cycle_start = 1'b1;
      host.write_reg(`CCES_ADDR_EVENT_ENABLE, 16'h0020);
      expect_reg("enable readback", `CCES_ADDR_EVENT_ENABLE, 16'hffff, 16'h0020);
      pulse(e);
      #1;
      check("irq pending", {15'h0000, irq}, 16'h0001);
      step(1);
      host.write_reg(ES, 16'h0020);
      #1;
      check("irq after clear", {15'h0000, irq}, 16'h0000);
      step(1);
      $display("test irq done");
   endtask

   task automatic t_level;
      lvl <= 2'h1;
      step(3);
      expect_reg("yellow level", LV, 16'hffff, 16'h0001);
      expect_reg("level changed flag", ES, 16'h1000, 16'h1000);
      lvl <= 2'h3;
      host.write_reg(LV, 16'h0000);
      expect_reg("unused level", LV, 16'hffff, 16'h0003);
      expect_reg("unmapped read", 16'h0002, 16'hffff, 16'h0000);
      host.write_reg(ES, 16'hffff);
      lvl <= 2'h0;
      step(2);
      cfg <= 1'b1;
      step(2);
      cfg <= 1'b0;
      step(2);
      expect_reg("wipe on config exit", ES, 16'hffff, 16'h0000);
      pulse('{fatal: 1'b1, default: 1'b0});
      #1;
      check("diag stop", {15'h0000, diag}, 16'h0001);
      check("red level", {14'h0000, lvl_out}, 16'h0002);
      step(1);
      expect_reg("fatal flags", ES, 16'h9000, 16'h9000);
      $display("test level done");
   endtask

   initial begin
      rstn = 1'b0;
      cfg = 1'b1;
      lvl = 2'h0;
      evt = '0;
      {rxf, rxe, txf, txe, hie} = '0;
      {fne, b0l} = 2'b00;
      slot = 8'h00;
      cyc = 6'h00;
      mt = 14'h0000;
      step(5);
      rstn <= 1'b1;
      step(1);
      t_reset();
      t_clear();
      t_causes();
      t_events();
      t_timer();
      t_irq();
      t_level();
      stop_test();
   end

   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      stop_test();
   end
endmodule
`default_nettype wire
